//--- hw/drive_prot_pkg.sv
// constants and types shared by the drive protection supervisor
package drive_prot_pkg;
	// clock and time bases
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_FAST_MS = 10;
	localparam int TICK_SLOW_S = 1;
	localparam int TICK_FAST_CYCLES = TICK_FAST_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TICK_SLOW_CYCLES =
		TICK_SLOW_S * 1000000000 / CLK_PERIOD_NS;
	localparam int TICK_W = 28;

	// currents in 0.1 % of rated, frequencies in 0.01 Hz
	localparam int CUR_W = 12;
	localparam int FREQ_W = 16;
	localparam logic [CUR_W-1:0] CUR_PHASE_LOST = 12'h032;   // 5 %
	localparam logic [CUR_W-1:0] CUR_RATED = 12'h3e8;        // 100 %
	localparam logic [CUR_W-1:0] CUR_CARRIER_LO_OFF = 12'h370; // 88 %
	localparam logic [CUR_W-1:0] CUR_CARRIER_HI = 12'h460;   // 112 %
	localparam logic [CUR_W-1:0] CUR_HIGH_ALARM = 12'h5dc;   // 150 %
	localparam logic [CUR_W-1:0] CUR_SOFT_LIMIT = 12'h5a0;   // plain default
	localparam logic [FREQ_W-1:0] FREQ_LOW = 16'h0258;       // 6 Hz
	localparam logic [FREQ_W-1:0] FREQ_HIGH = 16'h02bc;      // 7 Hz

	// setting ranges and defaults
	localparam logic [1:0] PHASE_SEL_ONE = 2'h1;
	localparam logic [1:0] PHASE_SEL_TWO = 2'h2;
	localparam logic [1:0] CARRIER_SEL_LOW = 2'h1;
	localparam logic [1:0] CARRIER_SEL_ALL = 2'h2;
	localparam logic [2:0] FAN_FAIL_RAMP = 3'h0;
	localparam logic [2:0] FAN_FAIL_COAST = 3'h1;
	localparam logic [2:0] FAN_FAIL_FAST = 3'h2;
	localparam logic [2:0] FAN_FAIL_ALARM = 3'h3;
	localparam logic [2:0] FAN_FAIL_REDUCED = 3'h4;
	localparam int FAN_DELAY_W = 9;
	localparam logic [FAN_DELAY_W-1:0] FAN_DELAY_MAX = 9'h12c;  // 300 s
	localparam int CAR_DELAY_W = 8;
	localparam logic [CAR_DELAY_W-1:0] CAR_DELAY_MAX = 8'hc8;   // 2.00 s
	localparam logic [3:0] SPEED_FACTOR_MIN = 4'h1;            // 0.1
	localparam logic [3:0] SPEED_FACTOR_MAX = 4'h9;            // 0.9
	localparam logic [19:0] SPEED_FACTOR_DIV = 20'h0000a;
	localparam logic signed [7:0] AMB_TEMP_MIN = -8'sh0a;     // -10 C
	localparam logic signed [7:0] AMB_TEMP_MAX = 8'sh32;      // 50 C
	localparam logic signed [7:0] AMB_TEMP_NOMINAL = 8'sh28;  // 40 C
	localparam logic [CUR_W-1:0] AMB_DERATE_PER_C = 12'h014;  // 2 %/C

	// pin input lanes of the synchroniser
	localparam int PIN_W = 4;
	localparam int PIN_RUN = 0;
	localparam int PIN_EARTH = 1;
	localparam int PIN_PU_LOSS = 2;
	localparam int PIN_FAN_FAIL = 3;

	typedef enum logic [1:0] {
		FAN_IDLE,
		FAN_RUNNING,
		FAN_HOLD
	} fan_state_e;

	typedef enum logic [1:0] {
		CAR_NORMAL,
		CAR_REDUCED,
		CAR_RELEASE
	} carrier_state_e;
endpackage : drive_prot_pkg

//--- hw/pin_sync.sv
// three-stage pin synchroniser with agreement filter
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// pins and filtered levels
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} sync_s;

	sync_s q;
	sync_s next_q;

	always_comb begin
		next_q = q;
		next_q.s1 = pin;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		// a change is accepted only once two later stages agree
		for (int i = 0; i < WIDTH; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				next_q.out[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign level = q.out;
endmodule : pin_sync

//--- hw/drive_protection_supervisor.sv
// protection supervisor for a motor drive: faults, alarms, fan, carrier
// Notes on behaviour
// - phase lost when current under 5 %
// - phase select 0 off, 1 one phase
// - select 2 needs two phases; coast
// - earth leak fault only when enabled
// - timer mode: fan on while running, delayed off
// - fan mode 1 keeps fan always on
// - fan off-delay 0 to 300 s
// - below 6 Hz derate overload, half at 0
// - derating off keeps overload level fixed
// - soft limit cuts voltage while current high
// - fan supply failure response by selection
// - selections 0 to 2 error; 3, 4 alarm
// - low-speed carrier reduction, 88 % or 7 Hz
// - entire-range mode adds 112 % above 7 Hz
// - entire-range restore uses hysteresis and delay
// - carrier delay 0 to 2 s, zero disables
// - high current alarm above 150 %, relay
// - power unit phase loss enable
// - ambient temperature derates rated current
// - reduced speed factor 0.1 to 0.9
module drive_protection_supervisor
#(
	parameter int TICK_FAST = drive_prot_pkg::TICK_FAST_CYCLES,
	parameter int TICK_SLOW = drive_prot_pkg::TICK_SLOW_CYCLES
) (
	// clock and reset
	input  wire logic                               clk,
	input  wire logic                               rst,
	// pins from the power stage
	input  wire logic                               run_cmd,
	input  wire logic                               earth_leak_detect,
	input  wire logic                               pu_phase_lost,
	input  wire logic                               fan_supply_fail,
	// measurements, same clock
	input  wire logic [drive_prot_pkg::CUR_W-1:0]   cur_u,
	input  wire logic [drive_prot_pkg::CUR_W-1:0]   cur_v,
	input  wire logic [drive_prot_pkg::CUR_W-1:0]   cur_w,
	input  wire logic [drive_prot_pkg::FREQ_W-1:0]  out_freq,
	input  wire logic [drive_prot_pkg::FREQ_W-1:0]  max_freq,
	input  wire logic [drive_prot_pkg::CUR_W-1:0]   overload_base_level,
	input  wire logic                               fault_reset,
	// settings
	input  wire logic [1:0]                         output_phase_loss_select,
	input  wire logic                               ground_fault_select,
	input  wire logic                               fan_operation_select,
	input  wire logic [8:0]                         fan_off_delay,
	input  wire logic signed [7:0]                  ambient_temp_setting,
	input  wire logic [1:0]                         installation_derating_select,
	input  wire logic                               low_speed_overload_select,
	input  wire logic                               soft_current_limit_select,
	input  wire logic [3:0]                         reduced_speed_factor,
	input  wire logic [2:0]                         fan_supply_failure_select,
	input  wire logic [1:0]                         carrier_reduction_select,
	input  wire logic [7:0]                         carrier_reduction_off_delay,
	input  wire logic                               high_current_alarm_select,
	input  wire logic                               power_unit_phase_loss_select,
	// faults and alarms
	output logic                                    output_phase_fault,
	output logic                                    earth_leak_fault,
	output logic                                    pu_phase_fault,
	output logic                                    fan_supply_error,
	output logic                                    fan_supply_alarm,
	output logic                                    overcurrent_warning,
	output logic                                    alarm_relay,
	// stop and limit commands
	output logic                                    coast_stop,
	output logic                                    ramp_stop,
	output logic                                    fast_stop,
	output logic                                    soft_current_limiter,
	output logic                                    speed_limit_en,
	output logic [drive_prot_pkg::FREQ_W-1:0]       speed_limit,
	output logic [drive_prot_pkg::CUR_W-1:0]        overload_level,
	output logic [drive_prot_pkg::CUR_W-1:0]        safe_rated_current,
	// fan and carrier
	output logic                                    fan_on,
	output logic                                    carrier_reduced
);
	import drive_prot_pkg::*;

	typedef struct packed {
		logic [TICK_W-1:0]      fast_cnt;
		logic [TICK_W-1:0]      slow_cnt;
		fan_state_e             fan_state;
		logic [FAN_DELAY_W-1:0] fan_secs;
		carrier_state_e         car_state;
		logic [CAR_DELAY_W-1:0] car_ticks;
		logic                   phase_flt;
		logic                   earth_flt;
		logic                   pu_flt;
		logic                   fan_err;
		logic                   fan_alm;
		logic                   hi_cur;
		logic                   relay;
		logic                   coast;
		logic                   ramp;
		logic                   fast;
		logic                   cur_lim;
		logic                   spd_en;
		logic [FREQ_W-1:0]      spd;
		logic [CUR_W-1:0]       ovl;
		logic [CUR_W-1:0]       rated;
		logic                   fan;
		logic                   car;
	} state_s;

	state_s q;
	state_s next_q;

	logic [PIN_W-1:0] pin_level;

	pin_sync #(
		.WIDTH (PIN_W)
	) u_pin_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   ({fan_supply_fail, pu_phase_lost, earth_leak_detect, run_cmd}),
		.level (pin_level)
	);

	// combinational helpers
	logic                   running;
	logic [1:0]             lost_phases;
	logic [CUR_W-1:0]       cur_max;
	logic                   tick_fast;
	logic                   tick_slow;
	logic [FAN_DELAY_W-1:0] fan_limit;
	logic [CAR_DELAY_W-1:0] car_limit;
	logic                   car_set;
	logic                   car_clear;
	logic [3:0]             factor;
	logic [19:0]            spd_prod;
	logic [23:0]            ovl_prod;
	logic [15:0]            ovl_sum;
	logic signed [7:0]      amb;
	logic [CUR_W-1:0]       amb_over;
	logic [CUR_W-1:0]       amb_cut;
	logic [2:0]             fan_sel;
	logic                   fan_fail_fault;

	always_comb begin
		running = pin_level[PIN_RUN];
		// phases under the lost level, counted
		lost_phases = 2'(cur_u < CUR_PHASE_LOST)
			+ 2'(cur_v < CUR_PHASE_LOST)
			+ 2'(cur_w < CUR_PHASE_LOST);
		cur_max = (cur_u > cur_v) ? cur_u : cur_v;
		cur_max = (cur_w > cur_max) ? cur_w : cur_max;
		tick_fast = (q.fast_cnt == TICK_W'(TICK_FAST - 1));
		tick_slow = (q.slow_cnt == TICK_W'(TICK_SLOW - 1));
		// out-of-range settings are held to their range ends
		fan_limit = (fan_off_delay > FAN_DELAY_MAX) ?
			FAN_DELAY_MAX : fan_off_delay;
		car_limit = (carrier_reduction_off_delay > CAR_DELAY_MAX) ?
			CAR_DELAY_MAX : carrier_reduction_off_delay;
		factor = reduced_speed_factor;
		if (factor < SPEED_FACTOR_MIN) begin
			factor = SPEED_FACTOR_MIN;
		end else if (factor > SPEED_FACTOR_MAX) begin
			factor = SPEED_FACTOR_MAX;
		end
		spd_prod = 20'(max_freq) * 20'(factor) / SPEED_FACTOR_DIV;
		// overload level follows (6 Hz + f) / 12 Hz below 6 Hz
		ovl_sum = FREQ_LOW + out_freq;
		ovl_prod = 24'(overload_base_level) * 24'(ovl_sum)
			/ 24'({FREQ_LOW, 1'b0});
		amb = ambient_temp_setting;
		if (amb > AMB_TEMP_MAX) begin
			amb = AMB_TEMP_MAX;
		end else if (amb < AMB_TEMP_MIN) begin
			amb = AMB_TEMP_MIN;
		end
		amb_over = '0;
		if (amb > AMB_TEMP_NOMINAL) begin
			amb_over = CUR_W'(unsigned'(amb - AMB_TEMP_NOMINAL));
		end
		amb_cut = CUR_W'(amb_over * AMB_DERATE_PER_C);
		// unknown selections above the range fall back to coasting
		fan_sel = (fan_supply_failure_select > FAN_FAIL_REDUCED) ?
			FAN_FAIL_COAST : fan_supply_failure_select;
		fan_fail_fault = pin_level[PIN_FAN_FAIL]
			&& (fan_sel <= FAN_FAIL_FAST);
		// carrier reduction entry and exit conditions
		car_set = 1'b0;
		car_clear = 1'b0;
		case (carrier_reduction_select)
			CARRIER_SEL_LOW: begin
				car_set = (out_freq < FREQ_LOW)
					&& (cur_max > CUR_RATED);
				car_clear = (cur_max < CUR_CARRIER_LO_OFF)
					|| (out_freq > FREQ_HIGH);
			end
			CARRIER_SEL_ALL: begin
				car_set = ((out_freq < FREQ_LOW) && (cur_max > CUR_RATED))
					|| ((out_freq > FREQ_HIGH)
					&& (cur_max > CUR_CARRIER_HI));
				// each band falls back 12 % below its entry level
				car_clear = (out_freq > FREQ_HIGH) ?
					(cur_max < CUR_RATED)
					: (cur_max < CUR_CARRIER_LO_OFF);
			end
			default: begin
				car_set = 1'b0;
				car_clear = 1'b1;
			end
		endcase
	end

	always_comb begin
		next_q = q;
		// time bases: 10 ms and 1 s
		next_q.fast_cnt = tick_fast ? '0 : q.fast_cnt + 1'b1;
		next_q.slow_cnt = tick_slow ? '0 : q.slow_cnt + 1'b1;

		// latched faults: a new event wins over a reset in the same cycle
		next_q.phase_flt = q.phase_flt && !fault_reset;
		if (running && !q.coast) begin
			if ((output_phase_loss_select == PHASE_SEL_ONE)
				&& (lost_phases >= 2'h1)) begin
				next_q.phase_flt = 1'b1;
			end
			if ((output_phase_loss_select == PHASE_SEL_TWO)
				&& (lost_phases >= 2'h2)) begin
				next_q.phase_flt = 1'b1;
			end
		end
		next_q.earth_flt = (q.earth_flt && !fault_reset)
			|| (ground_fault_select && pin_level[PIN_EARTH]);
		next_q.pu_flt = (q.pu_flt && !fault_reset)
			|| (power_unit_phase_loss_select
			&& pin_level[PIN_PU_LOSS]);
		next_q.fan_err = (q.fan_err && !fault_reset)
			|| fan_fail_fault;

		// alarms follow their conditions
		next_q.fan_alm = pin_level[PIN_FAN_FAIL]
			&& (fan_sel >= FAN_FAIL_ALARM);
		next_q.hi_cur = high_current_alarm_select
			&& (cur_max > CUR_HIGH_ALARM);
		next_q.relay = next_q.hi_cur;

		// stop responses
		next_q.coast = next_q.phase_flt || next_q.earth_flt
			|| next_q.pu_flt
			|| (next_q.fan_err && (fan_sel == FAN_FAIL_COAST));
		next_q.ramp = next_q.fan_err
			&& (fan_sel == FAN_FAIL_RAMP);
		next_q.fast = next_q.fan_err
			&& (fan_sel == FAN_FAIL_FAST);
		next_q.spd_en = next_q.fan_alm
			&& (fan_sel == FAN_FAIL_REDUCED);
		next_q.spd = spd_prod[FREQ_W-1:0];

		// soft current limit
		next_q.cur_lim = soft_current_limit_select
			&& (cur_max >= CUR_SOFT_LIMIT);

		// transistor overload level
		if (low_speed_overload_select && (out_freq < FREQ_LOW)) begin
			next_q.ovl = ovl_prod[CUR_W-1:0];
		end else begin
			next_q.ovl = overload_base_level;
		end

		// ambient derating of the rated current
		if (installation_derating_select != 2'h0) begin
			next_q.rated = CUR_RATED - amb_cut;
		end else begin
			next_q.rated = CUR_RATED;
		end

		// heatsink fan
		case (q.fan_state)
			FAN_IDLE: begin
				if (running) begin
					next_q.fan_state = FAN_RUNNING;
				end
			end
			FAN_RUNNING: begin
				if (!running) begin
					next_q.fan_state = FAN_HOLD;
					next_q.fan_secs = '0;
				end
			end
			FAN_HOLD: begin
				if (running) begin
					next_q.fan_state = FAN_RUNNING;
				end else if (q.fan_secs >= fan_limit) begin
					next_q.fan_state = FAN_IDLE;
				end else if (tick_slow) begin
					next_q.fan_secs = q.fan_secs + 1'b1;
				end
			end
			default: begin
				next_q.fan_state = FAN_IDLE;
			end
		endcase
		// the seconds base is free-running, so the first second is short
		next_q.fan = fan_operation_select
			|| (next_q.fan_state != FAN_IDLE);

		// carrier frequency reduction
		case (q.car_state)
			CAR_NORMAL: begin
				if (car_set && (car_limit != '0)) begin
					next_q.car_state = CAR_REDUCED;
				end
			end
			CAR_REDUCED: begin
				if (car_limit == '0) begin
					next_q.car_state = CAR_NORMAL;
				end else if (car_clear) begin
					if (carrier_reduction_select == CARRIER_SEL_ALL) begin
						next_q.car_state = CAR_RELEASE;
						next_q.car_ticks = '0;
					end else begin
						next_q.car_state = CAR_NORMAL;
					end
				end
			end
			CAR_RELEASE: begin
				if (car_limit == '0) begin
					next_q.car_state = CAR_NORMAL;
				end else if (car_set) begin
					next_q.car_state = CAR_REDUCED;
				end else if (q.car_ticks >= car_limit) begin
					next_q.car_state = CAR_NORMAL;
				end else if (tick_fast) begin
					next_q.car_ticks = q.car_ticks + 1'b1;
				end
			end
			default: begin
				next_q.car_state = CAR_NORMAL;
			end
		endcase
		next_q.car = (next_q.car_state != CAR_NORMAL);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
			q.rated <= CUR_RATED;
		end else begin
			q <= next_q;
		end
	end

	assign output_phase_fault = q.phase_flt;
	assign earth_leak_fault = q.earth_flt;
	assign pu_phase_fault = q.pu_flt;
	assign fan_supply_error = q.fan_err;
	assign fan_supply_alarm = q.fan_alm;
	assign overcurrent_warning = q.hi_cur;
	assign alarm_relay = q.relay;
	assign coast_stop = q.coast;
	assign ramp_stop = q.ramp;
	assign fast_stop = q.fast;
	assign soft_current_limiter = q.cur_lim;
	assign speed_limit_en = q.spd_en;
	assign speed_limit = q.spd;
	assign overload_level = q.ovl;
	assign safe_rated_current = q.rated;
	assign fan_on = q.fan;
	assign carrier_reduced = q.car;
endmodule : drive_protection_supervisor

//--- verification/drive_prot_properties.sv
// concurrent checks on the drive protection supervisor ports
module drive_prot_properties
	import drive_prot_pkg::*;
#(
	parameter int TICK_FAST = 10,
	parameter int TICK_SLOW = 40
) (
	// clock and reset
	input wire logic              clk,
	input wire logic              rst,
	// watched inputs
	input wire logic [CUR_W-1:0]  cur_u,
	input wire logic [CUR_W-1:0]  cur_v,
	input wire logic [CUR_W-1:0]  cur_w,
	input wire logic [FREQ_W-1:0] out_freq,
	input wire logic [CUR_W-1:0]  overload_base_level,
	input wire logic              fault_reset,
	input wire logic              fan_operation_select,
	input wire logic [1:0]        installation_derating_select,
	input wire logic              low_speed_overload_select,
	input wire logic              soft_current_limit_select,
	input wire logic [7:0]        carrier_reduction_off_delay,
	input wire logic              high_current_alarm_select,
	// watched outputs
	input wire logic              output_phase_fault,
	input wire logic              earth_leak_fault,
	input wire logic              pu_phase_fault,
	input wire logic              fan_supply_alarm,
	input wire logic              overcurrent_warning,
	input wire logic              alarm_relay,
	input wire logic              coast_stop,
	input wire logic              soft_current_limiter,
	input wire logic              speed_limit_en,
	input wire logic [CUR_W-1:0]  overload_level,
	input wire logic [CUR_W-1:0]  safe_rated_current,
	input wire logic              fan_on,
	input wire logic              carrier_reduced
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0]       settle;
	logic [CUR_W-1:0] peak;
	logic             ok;
	// the first edges after reset still carry reset-time inputs
	always_ff @(posedge clk) begin
		if (rst)
			settle <= 2'h0;
		else if (settle != 2'h3)
			settle <= settle + 2'h1;
	end
	always_comb begin
		peak = (cur_u > cur_v) ? cur_u : cur_v;
		peak = (cur_w > peak) ? cur_w : peak;
		ok = settle == 2'h3;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_relay_follows: assert property (
		alarm_relay == overcurrent_warning) else $error("relay differs");
	a_warn_level: assert property (ok |=> overcurrent_warning ==
		$past(high_current_alarm_select && peak > CUR_HIGH_ALARM))
		else $error("warning level wrong");
	a_limit_level: assert property (ok |=> soft_current_limiter ==
		$past(soft_current_limit_select && peak >= CUR_SOFT_LIMIT))
		else $error("limiter level wrong");
	a_overload_flat: assert property (
		ok && (!low_speed_overload_select || out_freq >= FREQ_LOW)
		|=> overload_level == $past(overload_base_level))
		else $error("overload level changed");
	a_overload_half: assert property (ok && low_speed_overload_select &&
		out_freq == 16'h0000
		|=> overload_level == ($past(overload_base_level) >> 1))
		else $error("overload not halved");
	a_rated_flat: assert property (ok && installation_derating_select ==
		2'h0 |=> safe_rated_current == CUR_RATED) else $error("rated moved");
	a_coast_cause: assert property (output_phase_fault ||
		earth_leak_fault || pu_phase_fault |-> coast_stop)
		else $error("fault without coast");
	a_fault_held: assert property (output_phase_fault &&
		!fault_reset |=> output_phase_fault) else $error("fault dropped");
	a_fan_always: assert property (ok && fan_operation_select ##1
		fan_operation_select |-> fan_on) else $error("fan off in mode 1");
	a_carrier_off: assert property (ok && carrier_reduction_off_delay ==
		8'h00 |=> !carrier_reduced) else $error("carrier reduced");
	a_speed_cause: assert property (
		speed_limit_en |-> fan_supply_alarm) else $error("limit w/o alarm");
	c_phase: cover property (output_phase_fault);
	c_carrier: cover property (carrier_reduced);
	c_speed: cover property (speed_limit_en);
endmodule : drive_prot_properties

bind drive_protection_supervisor drive_prot_properties #(
	.TICK_FAST(TICK_FAST),
	.TICK_SLOW(TICK_SLOW)
) i_props (.*);

//--- verification/drive_protection_supervisor_tb_top.sv
// self-checking bench for the drive protection supervisor
module drive_protection_supervisor_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import drive_prot_pkg::*;
	typedef struct {int sel; logic [15:0] val;} note_s;
	localparam int OPF = 0, ELF = 1, PUF = 2, FSE = 3, FSA = 4, OCW = 5;
	localparam int RELAY = 6, COAST = 7, RAMP = 8, FAST = 9, LIM = 10;
	localparam int SLE = 11, FAN = 12, CAR = 13, SPD = 14, OVL = 15;
	localparam int RATED = 16;
	logic clk = 0, rst = 1, run_cmd = 0, earth_leak_detect = 0;
	logic pu_phase_lost = 0, fan_supply_fail = 0, fault_reset = 0;
	logic [CUR_W-1:0] cur_u = 12'h1f4, cur_v = 12'h1f4, cur_w = 12'h1f4;
	logic [CUR_W-1:0] overload_base_level = 12'h320;
	logic [FREQ_W-1:0] out_freq = 16'h03e8, max_freq = 16'h1770;
	logic [1:0] output_phase_loss_select = 2'h1;
	logic [1:0] installation_derating_select = 2'h0;
	logic [1:0] carrier_reduction_select = 2'h0;
	logic ground_fault_select = 1, fan_operation_select = 0;
	logic low_speed_overload_select = 1, soft_current_limit_select = 0;
	logic high_current_alarm_select = 0, power_unit_phase_loss_select = 1;
	logic [8:0] fan_off_delay = 9'h004;
	logic signed [7:0] ambient_temp_setting = 8'sh28;
	logic [3:0] reduced_speed_factor = 4'h8;
	logic [2:0] fan_supply_failure_select = 3'h1;
	logic [7:0] carrier_reduction_off_delay = 8'h02;
	logic output_phase_fault, earth_leak_fault, pu_phase_fault;
	logic fan_supply_error, fan_supply_alarm, overcurrent_warning;
	logic alarm_relay, coast_stop, ramp_stop, fast_stop, fan_on;
	logic soft_current_limiter, speed_limit_en, carrier_reduced;
	logic [FREQ_W-1:0] speed_limit;
	logic [CUR_W-1:0] overload_level, safe_rated_current;
	int bad_count = 0, cmp_count = 0;
	int fq [4] = '{32'h0, 32'h12c, 32'h257, 32'h2bc};
	logic [31:0] lfsr = 32'h1224a808;
	note_s q [$];
	event look;
	wire [13:0] flags = {carrier_reduced, fan_on, speed_limit_en,
		soft_current_limiter, fast_stop, ramp_stop, coast_stop, alarm_relay,
		overcurrent_warning, fan_supply_alarm, fan_supply_error,
		pu_phase_fault, earth_leak_fault, output_phase_fault};

	// short ticks keep the fan and carrier timers inside a brief run
	drive_protection_supervisor #(.TICK_FAST(10), .TICK_SLOW(40)) i_dut (.*);

	always #2 clk = ~clk;

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	function automatic logic [15:0] obs(int s);
		if (s < 14) return {15'h0, flags[s]};
		if (s == SPD) return speed_limit;
		if (s == OVL) return {4'h0, overload_level};
		return {4'h0, safe_rated_current};
	endfunction : obs
	task automatic check(logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic note(int s, logic [15:0] v);
		q.push_back('{s, v});
		->look;
	endtask : note
	// inputs always move one time unit after the rising edge
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic clear();
		fault_reset = 1;
		step(2);
		fault_reset = 0;
		step(1);
	endtask : clear
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	initial begin : watch
		note_s n;
		forever begin
			@(look);
			while (q.size() > 0) begin
				n = q.pop_front();
				check(obs(n.sel), n.val);
			end
		end
	end

	initial begin
		#(4 * 20000);
		bad_count++;
		summarize();
	end

	initial begin
		step(12);
		note(FAN, 0); note(OPF, 0); note(RATED, 16'h03e8);
		rst = 0; run_cmd = 1; step(8);
		note(FAN, 1);
		for (int s = 0; s < 3; s++) begin
			output_phase_loss_select = s[1:0];
			cur_u = 12'h032; step(2); note(OPF, 0);
			cur_u = 12'h031; step(2); note(OPF, s == 1);
			cur_v = 12'h031; step(2); note(OPF, s != 0);
			note(COAST, s != 0);
			cur_u = 12'h1f4; cur_v = 12'h1f4; step(3);
			note(OPF, s != 0);
			clear(); note(OPF, 0); note(COAST, 0);
		end
		for (int e = 0; e < 2; e++) begin
			ground_fault_select = e[0]; power_unit_phase_loss_select = e[0];
			earth_leak_detect = 1; step(6); note(ELF, e);
			earth_leak_detect = 0; pu_phase_lost = 1; step(6);
			note(PUF, e); note(COAST, e);
			pu_phase_lost = 0; step(6); clear();
			note(ELF, 0); note(PUF, 0);
		end
		for (int f = 0; f < 5; f++) begin
			fan_supply_failure_select = f[2:0];
			max_freq = 16'(rnd()); reduced_speed_factor = 4'(2 * f + 1);
			fan_supply_fail = 1; step(6);
			note(RAMP, f == 0); note(COAST, f == 1); note(FAST, f == 2);
			note(FSE, f < 3); note(FSA, f > 2); note(SLE, f == 4);
			if (f == 4) note(SPD, 16'(32'(max_freq) * 32'h9 / 32'ha));
			fan_supply_fail = 0; step(6); clear();
			note(FSE, 0); note(FSA, 0); note(COAST, 0);
		end
		run_cmd = 0; step(60); note(FAN, 1);
		run_cmd = 1; step(6); note(FAN, 1);
		run_cmd = 0; step(110); note(FAN, 1);
		step(60); note(FAN, 0);
		fan_operation_select = 1; step(2); note(FAN, 1);
		fan_operation_select = 0;
		for (int i = 0; i < 4; i++) begin
			overload_base_level = 12'(rnd()); out_freq = 16'(fq[i]); step(2);
			note(OVL, fq[i] < 32'h258 ? 16'(overload_base_level *
				(32'h258 + fq[i]) / 32'h4b0) : {4'h0, overload_base_level});
		end
		out_freq = 16'h0000; low_speed_overload_select = 0; step(2);
		note(OVL, {4'h0, overload_base_level});
		soft_current_limit_select = 1; high_current_alarm_select = 1;
		cur_w = 12'h59f; step(2); note(LIM, 0);
		cur_w = 12'h5dc; step(2); note(LIM, 1); note(OCW, 0);
		cur_w = 12'h5dd; step(2); note(OCW, 1); note(RELAY, 1);
		soft_current_limit_select = 0; high_current_alarm_select = 0; step(2);
		note(LIM, 0); note(OCW, 0);
		cur_w = 12'h1f4; carrier_reduction_select = 2'h1;
		out_freq = 16'h012c; cur_u = 12'h3e9; step(2); note(CAR, 1);
		cur_u = 12'h370; step(2); note(CAR, 1);
		cur_u = 12'h36f; step(2); note(CAR, 0);
		cur_u = 12'h3e9; step(2); out_freq = 16'h02bd; step(2);
		note(CAR, 0);
		cur_u = 12'h461; step(2); note(CAR, 0);
		carrier_reduction_select = 2'h2; step(2); note(CAR, 1);
		cur_u = 12'h3e8; step(40); note(CAR, 1);
		cur_u = 12'h3e7; step(2); note(CAR, 1);
		step(30); note(CAR, 0);
		cur_u = 12'h461; carrier_reduction_off_delay = 8'h00; step(2);
		note(CAR, 0);
		carrier_reduction_select = 2'h0; carrier_reduction_off_delay = 8'h02;
		step(2); note(CAR, 0);
		cur_u = 12'h1f4; installation_derating_select = 2'h1;
		ambient_temp_setting = 8'sh2d; step(2); note(RATED, 16'h0384);
		ambient_temp_setting = 8'sh3c; step(2); note(RATED, 16'h0320);
		installation_derating_select = 2'h0; step(2);
		note(RATED, 16'h03e8);
		#1;
		summarize();
	end
endmodule : drive_protection_supervisor_tb_top
